//--- flash_erase_pkg.sv
package flash_erase_pkg;

  // Bus and register map
  localparam int          ADDR_W        = 12;
  localparam logic [11:0] OFS_POINTER   = 12'h000;
  localparam logic [11:0] OFS_CONTROL   = 12'h004;
  localparam logic [11:0] OFS_UNLOCK    = 12'h008;
  localparam logic [11:0] OFS_STATUS    = 12'h00C;

  // Program address pointer
  localparam int PTR_W      = 22;
  localparam int BLOCK_LSB  = 5;
  localparam int BLOCK_W    = PTR_W - BLOCK_LSB;
  localparam int BLOCK_WORDS = 32;
  localparam int BLOCK_BYTES = 64;

  // Control register bit positions
  localparam int CTRL_START       = 0;
  localparam int CTRL_WRITE_GATE  = 1;
  localparam int CTRL_ERASE_SEL   = 2;
  localparam int CTRL_CONFIG_SEL  = 3;
  localparam int CTRL_PROGRAM_SEL = 4;

  // Status register bit positions
  localparam int STAT_BUSY   = 0;
  localparam int STAT_REFUSE = 1;

  // Unlock keys
  localparam logic [7:0] UNLOCK_KEY_FIRST  = 8'h55;
  localparam logic [7:0] UNLOCK_KEY_SECOND = 8'hAA;

  // Reset values
  localparam logic [21:0] POINTER_RST = 22'h00_0000;
  localparam logic [31:0] RDATA_RST   = 32'h0000_0000;

  // Erase timing
  localparam int ERASE_TIME_US = 2000;
  localparam int CLK_MHZ       = 10;
  localparam int ERASE_CYCLES  = ERASE_TIME_US * CLK_MHZ;
  localparam int CNT_W         = 24;

  typedef enum logic [2:0] {
    UNL_IDLE  = 3'b001,
    UNL_FIRST = 3'b010,
    UNL_ARMED = 3'b100
  } unlock_t;

  typedef enum logic [1:0] {
    SEQ_IDLE  = 2'b01,
    SEQ_ERASE = 2'b10
  } seq_t;

endpackage : flash_erase_pkg

//--- erase_timer_if.sv
`timescale 1ns/1ps
interface erase_timer_if;
  logic                                  start;
  logic [flash_erase_pkg::CNT_W-1:0]     cycles;
  logic                                  done;

  modport sequencer (output start, output cycles, input done);
  modport timer     (input start, input cycles, output done);
endinterface : erase_timer_if

//--- erase_timer.sv
`timescale 1ns/1ps
module erase_timer (
  input  wire logic   pclk,
  input  wire logic   presetn,
  erase_timer_if.timer tmr
);

  typedef struct packed {
    logic [flash_erase_pkg::CNT_W-1:0] cnt;
    logic                              run;
    logic                              done;
  } timer_state_t;

  timer_state_t st_ff;
  timer_state_t nxt_st;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    nxt_st      = st_ff;
    nxt_st.done = 1'b0;
    if (tmr.start && !st_ff.run) begin
      // Load one less so done lands exactly after the programmed count
      nxt_st.cnt = tmr.cycles - flash_erase_pkg::CNT_W'(1);
      nxt_st.run = 1'b1;
    end else if (st_ff.run) begin
      if (st_ff.cnt == '0) begin
        nxt_st.run  = 1'b0;
        nxt_st.done = 1'b1;
      end else begin
        nxt_st.cnt = st_ff.cnt - flash_erase_pkg::CNT_W'(1);
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign tmr.done = st_ff.done;

endmodule : erase_timer

//--- flash_block_erase_sequencer.sv
`timescale 1ns/1ps
// Operation
// - Erase unit is one 64-byte block
// - Self-started erase never exceeds one block
// - Pointer bits 21:5 pick block
// - No erase while write gate clear
// - Erase select makes start a block erase
// - Start bit after unlock begins erase
// - Core stalled for whole long write
// - Internal timer ends the erase
// - Erase lasts about 2 ms
module flash_block_erase_sequencer #(
  parameter int ERASE_CYCLES = flash_erase_pkg::ERASE_CYCLES
) (
  input  wire logic                                    pclk,
  input  wire logic                                    presetn,
  input  wire logic                                    psel,
  input  wire logic                                    penable,
  input  wire logic                                    pwrite,
  input  wire logic [flash_erase_pkg::ADDR_W-1:0]      paddr,
  input  wire logic [31:0]                             pwdata,
  output logic      [31:0]                             prdata,
  output logic                                         pready,
  output logic                                         pslverr,
  output logic                                         cpu_stall,
  output logic                                         flash_erase_req,
  output logic      [flash_erase_pkg::BLOCK_W-1:0]     flash_block_addr,
  output logic                                         erase_done
);

  typedef struct packed {
    flash_erase_pkg::seq_t                  seq;
    flash_erase_pkg::unlock_t               unlock;
    logic [flash_erase_pkg::PTR_W-1:0]      pointer;
    logic                                   write_gate;
    logic                                   erase_sel;
    logic                                   config_sel;
    logic                                   program_sel;
    logic                                   refused;
    logic [31:0]                            prdata;
    logic                                   pready;
    logic                                   pslverr;
    logic                                   stall;
    logic                                   erase_req;
    logic [flash_erase_pkg::BLOCK_W-1:0]    block_addr;
    logic                                   erase_done;
  } seq_state_t;

  seq_state_t st_ff;
  seq_state_t nxt_st;

  erase_timer_if tmr_if ();

  erase_timer u_erase_timer (
    .pclk    (pclk),
    .presetn (presetn),
    .tmr     (tmr_if.timer)
  );

  function automatic logic addr_is(input logic [flash_erase_pkg::ADDR_W-1:0] a,
                                   input logic [flash_erase_pkg::ADDR_W-1:0] ofs);
    addr_is = (a == ofs);
  endfunction : addr_is

  // Unmapped offsets answer with an error; a write there changes no register but still resets the unlock chain
  function automatic logic addr_mapped(input logic [flash_erase_pkg::ADDR_W-1:0] a);
    addr_mapped = addr_is(a, flash_erase_pkg::OFS_POINTER) ||
                  addr_is(a, flash_erase_pkg::OFS_CONTROL) ||
                  addr_is(a, flash_erase_pkg::OFS_UNLOCK)  ||
                  addr_is(a, flash_erase_pkg::OFS_STATUS);
  endfunction : addr_mapped

  logic access;
  logic wr_done_any;
  logic wr_commit;
  logic rd_commit;
  logic start_req;
  logic start_ok;
  logic busy;
  logic armed;
  logic first_seen;

  logic sel_pointer;
  logic sel_control;
  logic sel_unlock;
  logic sel_status;
  logic key_first;
  logic key_second;

  // Decoded once, shared by read mux, write path and start gate
  assign sel_pointer = addr_is(paddr, flash_erase_pkg::OFS_POINTER);
  assign sel_control = addr_is(paddr, flash_erase_pkg::OFS_CONTROL);
  assign sel_unlock  = addr_is(paddr, flash_erase_pkg::OFS_UNLOCK);
  assign sel_status  = addr_is(paddr, flash_erase_pkg::OFS_STATUS);
  assign key_first   = (pwdata[7:0] == flash_erase_pkg::UNLOCK_KEY_FIRST);
  assign key_second  = (pwdata[7:0] == flash_erase_pkg::UNLOCK_KEY_SECOND);
  assign armed       = (st_ff.unlock == flash_erase_pkg::UNL_ARMED);
  assign first_seen  = (st_ff.unlock == flash_erase_pkg::UNL_FIRST);

  // One wait state: pready rises on the first edge that sees penable high
  assign access      = psel && penable && !st_ff.pready;
  assign wr_done_any = psel && penable && st_ff.pready && pwrite;
  assign wr_commit   = wr_done_any && addr_mapped(paddr);
  assign rd_commit   = access && !pwrite;
  assign busy        = (st_ff.seq == flash_erase_pkg::SEQ_ERASE);
  assign start_req   = wr_commit && !busy && sel_control
                       && pwdata[flash_erase_pkg::CTRL_START];

  // Gate uses the values written together with the start bit
  assign start_ok  = start_req
                     && armed
                     && pwdata[flash_erase_pkg::CTRL_WRITE_GATE]
                     && pwdata[flash_erase_pkg::CTRL_ERASE_SEL]
                     && pwdata[flash_erase_pkg::CTRL_PROGRAM_SEL]
                     && !pwdata[flash_erase_pkg::CTRL_CONFIG_SEL];

  assign tmr_if.start  = start_ok;
  assign tmr_if.cycles = flash_erase_pkg::CNT_W'(ERASE_CYCLES);

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    nxt_st            = st_ff;
    nxt_st.pready     = access;
    nxt_st.pslverr    = access && !addr_mapped(paddr);
    nxt_st.erase_done = 1'b0;

    // Read data captured one edge ahead, stable when pready rises
    if (rd_commit) begin
      nxt_st.prdata = flash_erase_pkg::RDATA_RST;
      if (sel_pointer) begin
        nxt_st.prdata[flash_erase_pkg::PTR_W-1:0] = st_ff.pointer;
      end else if (sel_control) begin
        nxt_st.prdata[flash_erase_pkg::CTRL_START]       = busy;
        nxt_st.prdata[flash_erase_pkg::CTRL_WRITE_GATE]  = st_ff.write_gate;
        nxt_st.prdata[flash_erase_pkg::CTRL_ERASE_SEL]   = st_ff.erase_sel;
        nxt_st.prdata[flash_erase_pkg::CTRL_CONFIG_SEL]  = st_ff.config_sel;
        nxt_st.prdata[flash_erase_pkg::CTRL_PROGRAM_SEL] = st_ff.program_sel;
      end else if (sel_status) begin
        nxt_st.prdata[flash_erase_pkg::STAT_BUSY]   = busy;
        nxt_st.prdata[flash_erase_pkg::STAT_REFUSE] = st_ff.refused;
      end
    end

    // Writes are dropped while erasing: the core is frozen then anyway
    if (wr_done_any && !busy) begin
      // Any write, mapped or not, breaks the key chain
      nxt_st.unlock = flash_erase_pkg::UNL_IDLE;
    end
    if (wr_commit && !busy) begin
      if (sel_pointer) begin
        nxt_st.pointer = pwdata[flash_erase_pkg::PTR_W-1:0];
      end else if (sel_control) begin
        nxt_st.write_gate  = pwdata[flash_erase_pkg::CTRL_WRITE_GATE];
        nxt_st.erase_sel   = pwdata[flash_erase_pkg::CTRL_ERASE_SEL];
        nxt_st.config_sel  = pwdata[flash_erase_pkg::CTRL_CONFIG_SEL];
        nxt_st.program_sel = pwdata[flash_erase_pkg::CTRL_PROGRAM_SEL];
      end else if (sel_unlock) begin
        if (key_first) begin
          nxt_st.unlock = flash_erase_pkg::UNL_FIRST;
        end else if (key_second && first_seen) begin
          nxt_st.unlock = flash_erase_pkg::UNL_ARMED;
        end
      end else if (sel_status) begin
        if (pwdata[flash_erase_pkg::STAT_REFUSE]) begin
          nxt_st.refused = 1'b0;
        end
      end
    end

    // Refusal set comes last so it beats a same-cycle clear
    if (start_req && !start_ok) begin
      nxt_st.refused = 1'b1;
    end

    // Only the timer ends the long write; software cannot cut it short
    unique case (st_ff.seq)
      flash_erase_pkg::SEQ_IDLE: begin
        if (start_ok) begin
          nxt_st.seq        = flash_erase_pkg::SEQ_ERASE;
          nxt_st.stall      = 1'b1;
          nxt_st.erase_req  = 1'b1;
          // Low pointer bits drop out: the block is always whole
          nxt_st.block_addr = st_ff.pointer[flash_erase_pkg::PTR_W-1:flash_erase_pkg::BLOCK_LSB];
        end
      end
      flash_erase_pkg::SEQ_ERASE: begin
        if (tmr_if.done) begin
          nxt_st.seq        = flash_erase_pkg::SEQ_IDLE;
          nxt_st.stall      = 1'b0;
          nxt_st.erase_req  = 1'b0;
          nxt_st.erase_done = 1'b1;
        end
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      // Enum fields need legal one-hot codes, not the all-zero pattern
      st_ff             <= '0;
      st_ff.seq         <= flash_erase_pkg::SEQ_IDLE;
      st_ff.unlock      <= flash_erase_pkg::UNL_IDLE;
      st_ff.pointer     <= flash_erase_pkg::POINTER_RST;
      st_ff.prdata      <= flash_erase_pkg::RDATA_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Every output is a flop of the state record
  assign prdata           = st_ff.prdata;
  assign pready           = st_ff.pready;
  assign pslverr          = st_ff.pslverr;
  assign cpu_stall        = st_ff.stall;
  assign flash_erase_req  = st_ff.erase_req;
  assign flash_block_addr = st_ff.block_addr;
  assign erase_done       = st_ff.erase_done;

endmodule : flash_block_erase_sequencer

//--- flash_erase_properties.sv
`timescale 1ns/1ps
module flash_erase_properties #(
  parameter int ERASE_CYCLES = flash_erase_pkg::ERASE_CYCLES
) (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        cpu_stall,
  input wire logic        flash_erase_req,
  input wire logic [16:0] flash_block_addr,
  input wire logic        erase_done
);
  logic        wr_done;
  logic        start_wr;
  logic [21:0] ptr_ff;
  logic        key1_ff;
  logic        key2_ff;
  logic [15:0] cnt_ff;

  assign wr_done  = psel && penable && pready && pwrite;
  assign start_wr = wr_done && paddr == flash_erase_pkg::OFS_CONTROL && pwdata[4:0] == 5'h17;

  // Shadow of the unlock history; stalled writes are ignored like in the block
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ptr_ff  <= '0;
      key1_ff <= 1'h0;
      key2_ff <= 1'h0;
      cnt_ff  <= '0;
    end else begin
      cnt_ff <= flash_erase_req ? cnt_ff + 16'h0001 : 16'h0000;
      if (wr_done && !cpu_stall) begin
        if (paddr == flash_erase_pkg::OFS_POINTER) ptr_ff <= pwdata[21:0];
        key1_ff <= paddr == flash_erase_pkg::OFS_UNLOCK && pwdata[7:0] == 8'h55;
        key2_ff <= key1_ff && paddr == flash_erase_pkg::OFS_UNLOCK && pwdata[7:0] == 8'hAA;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  AST_STALL_MATCHES_REQ: assert property (cpu_stall == flash_erase_req)
    else $error("stall and erase request differ");
  AST_ERASE_LENGTH: assert property ($fell(flash_erase_req) |-> cnt_ff == ERASE_CYCLES + 1)
    else $error("erase length wrong");
  AST_DONE_AT_END: assert property ($fell(flash_erase_req) |-> erase_done)
    else $error("no done pulse at erase end");
  AST_DONE_ONLY_AT_END: assert property (erase_done |-> !flash_erase_req && $past(flash_erase_req))
    else $error("stray done pulse");
  AST_START_WORD: assert property ($rose(flash_erase_req) |-> $past(start_wr))
    else $error("erase began without a valid start write");
  AST_UNLOCK_BEFORE_START: assert property ($rose(flash_erase_req) |-> $past(key2_ff))
    else $error("erase began without unlock pair");
  AST_BLOCK_FROM_POINTER: assert property ($rose(flash_erase_req) |-> flash_block_addr == ptr_ff[21:5])
    else $error("block address not from pointer");
  AST_BLOCK_HOLDS: assert property (flash_erase_req |=> $stable(flash_block_addr))
    else $error("block address moved during erase");
  AST_BUS_ONE_WAIT: assert property (psel && !penable |=> !pready ##1 pready)
    else $error("bus wait state wrong");

  cover property ($rose(flash_erase_req));
  cover property (erase_done);
  cover property (pslverr);
endmodule : flash_erase_properties

bind flash_block_erase_sequencer flash_erase_properties #(.ERASE_CYCLES(ERASE_CYCLES)) chk_u (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr,
  .cpu_stall, .flash_erase_req, .flash_block_addr, .erase_done);

//--- flash_array_model.sv
`timescale 1ns/1ps
module flash_array_model (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        erase_req,
  input  wire logic [16:0] block_addr,
  output int               erase_count,
  output logic      [16:0] last_block
);
  logic req_ff;

  // One request wipes exactly one 64-byte block, never more
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      req_ff      <= 1'h0;
      erase_count <= 0;
      last_block  <= '0;
    end else begin
      req_ff <= erase_req;
      if (erase_req && !req_ff) begin
        erase_count <= erase_count + 1;
        last_block  <= block_addr;
      end
    end
  end
endmodule : flash_array_model

//--- flash_block_erase_sequencer_tb.sv
`timescale 1ns/1ps
module flash_block_erase_sequencer_tb;
  localparam int ERASE_CYCLES = 20;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic        cpu_stall, flash_erase_req, erase_done;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, ptr;
  logic [16:0] flash_block_addr, last_block;
  int          num_errors, checks_done, erase_count, n, d;

  flash_block_erase_sequencer #(.ERASE_CYCLES(ERASE_CYCLES)) dut_u (.pclk, .presetn, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .cpu_stall,
    .flash_erase_req, .flash_block_addr, .erase_done);
  flash_array_model model_u (.pclk, .presetn, .erase_req(flash_erase_req),
    .block_addr(flash_block_addr), .erase_count, .last_block);

  initial pclk = 1'h0;
  always #50 pclk = ~pclk;

  ////////////////////////////////////////////////////////////////////////////
  task check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task xfer(input logic [11:0] a, input logic w, input logic [31:0] dat);
    int k;
    @(posedge pclk);
    psel    <= 1'h1;
    penable <= 1'h0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= dat;
    @(posedge pclk);
    penable <= 1'h1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'h1 && k < 50);
    if (k >= 50) num_errors++;
    rd = prdata;
    err = pslverr;
    psel    <= 1'h0;
    penable <= 1'h0;
  endtask : xfer

  task rchk(input logic [11:0] a, input logic [31:0] exp);
    xfer(a, 1'h0, 32'h0000_0000);
    check(rd, exp);
  endtask : rchk

  task start_seq(input logic [31:0] ctl, input logic [7:0] k1, input logic [7:0] k2,
                 input logic meddle);
    xfer(flash_erase_pkg::OFS_CONTROL, 1'h1, ctl & 32'h0000_001E);
    xfer(flash_erase_pkg::OFS_UNLOCK, 1'h1, {24'h00_0000, k1});
    xfer(flash_erase_pkg::OFS_UNLOCK, 1'h1, {24'h00_0000, k2});
    if (meddle) xfer(flash_erase_pkg::OFS_POINTER, 1'h1, 32'h0000_0040);
    xfer(flash_erase_pkg::OFS_CONTROL, 1'h1, ctl);
  endtask : start_seq

  task report_and_stop;
    if (num_errors == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : report_and_stop

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    #(100 * 20000);
    num_errors++;
    report_and_stop();
  end

  initial begin
    {presetn, psel, penable, pwrite} = 4'h0;
    paddr  = 12'h000;
    pwdata = 32'h0000_0000;
    repeat (8) @(posedge pclk);
    presetn <= 1'h1;
    check({cpu_stall, flash_erase_req, erase_done, flash_block_addr}, 32'h0000_0000);
    rchk(flash_erase_pkg::OFS_POINTER, 32'h0000_0000);
    rchk(flash_erase_pkg::OFS_STATUS, 32'h0000_0000);
    xfer(flash_erase_pkg::OFS_POINTER, 1'h1, 32'hFFFF_FFFF);
    rchk(flash_erase_pkg::OFS_POINTER, 32'h003F_FFFF);
    rchk(flash_erase_pkg::OFS_UNLOCK, 32'h0000_0000);
    rchk(12'h010, 32'h0000_0000);
    check({31'h0000_0000, err}, 32'h0000_0001);
    // Each start below lacks one condition and must leave the array alone
    for (int i = 0; i < 7; i++) begin
      case (i)
        0: start_seq(32'h0000_0015, 8'h55, 8'hAA, 1'h0);
        1: start_seq(32'h0000_0013, 8'h55, 8'hAA, 1'h0);
        2: start_seq(32'h0000_001F, 8'h55, 8'hAA, 1'h0);
        3: start_seq(32'h0000_0007, 8'h55, 8'hAA, 1'h0);
        4: start_seq(32'h0000_0017, 8'hAA, 8'h55, 1'h0);
        5: start_seq(32'h0000_0017, 8'h55, 8'hAA, 1'h1);
        default: begin
          xfer(flash_erase_pkg::OFS_UNLOCK, 1'h1, 32'h0000_0055);
          xfer(flash_erase_pkg::OFS_UNLOCK, 1'h1, 32'h0000_00AA);
          xfer(12'h010, 1'h1, 32'h0000_0000);
          xfer(flash_erase_pkg::OFS_CONTROL, 1'h1, 32'h0000_0017);
        end
      endcase
      repeat (3) @(posedge pclk);
      check({31'h0000_0000, cpu_stall}, 32'h0000_0000);
      rchk(flash_erase_pkg::OFS_STATUS, 32'h0000_0002);
      xfer(flash_erase_pkg::OFS_STATUS, 1'h1, 32'h0000_0002);
      rchk(flash_erase_pkg::OFS_STATUS, 32'h0000_0000);
    end
    check(erase_count, 32'h0000_0000);
    // Last-in-block pointers, one mid-array and one in the top block: low five bits must not matter
    for (int j = 0; j < 2; j++) begin
      ptr = j ? 32'h003F_FFFF : 32'h0012_345F;
      xfer(flash_erase_pkg::OFS_POINTER, 1'h1, ptr);
      start_seq(32'h0000_0017, 8'h55, 8'hAA, 1'h0);
      n = 0;
      d = 0;
      repeat (60) begin
        @(posedge pclk);
        if (cpu_stall === 1'h1) n++;
        if (erase_done === 1'h1) d++;
      end
      check(n, ERASE_CYCLES + 1);
      check(d, 32'h0000_0001);
      check({15'h0000, flash_block_addr}, ptr >> 5);
      check({15'h0000, last_block}, ptr >> 5);
      check(erase_count, j + 1);
      rchk(flash_erase_pkg::OFS_STATUS, 32'h0000_0000);
      rchk(flash_erase_pkg::OFS_CONTROL, 32'h0000_0016);
    end
    report_and_stop();
  end
endmodule : flash_block_erase_sequencer_tb
